// File: verilog/adcs_defs.vh
// constants shared by the converter sequencer and its approximation engine
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// ---------------------------------------------------------------
// result, control word and bit counter sizes
// ---------------------------------------------------------------
`define ADCS_DATA_BITS 12
`define ADCS_CTRL_BITS 8
`define ADCS_CNT_W 4

// ---------------------------------------------------------------
// control byte field positions, most significant first
// ---------------------------------------------------------------
`define ADCS_START_POS 7
`define ADCS_SEL_MSB_POS 6
`define ADCS_SEL_MID_POS 5
`define ADCS_SEL_LSB_POS 4
`define ADCS_POL_POS 3
`define ADCS_CFG_POS 2
`define ADCS_PD_HI_POS 1
`define ADCS_PD_LO_POS 0

// ---------------------------------------------------------------
// serial clock falling edge positions in the control byte
// ---------------------------------------------------------------
`define ADCS_TRACK_BIT_CNT 4'h5
`define ADCS_HOLD_BIT_CNT 4'h8
`define ADCS_CNT_FIRST 4'h1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ADCS_CTRL_RST 8'h00
`define ADCS_RESULT_RST 12'h000
`define ADCS_CNT_RST 4'h0

`endif

// File: verilog/adcs_sar.v
// successive approximation engine: one trial decision per step pulse
`timescale 1ns/10ps
`default_nettype none
`include "adcs_defs.vh"

module adcs_sar #(
    parameter W = `ADCS_DATA_BITS
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // sequencing
    input wire start_i,
    input wire step_i,
    input wire comp_i,
    // results
    output wire [W-1:0] trial_o,
    output wire bit_o,
    output wire busy_o,
    output wire done_o,
    output wire [W-1:0] result_o
);

    reg [W-1:0] trial_r;
    reg [W-1:0] mask_r;
    reg [W-1:0] result_r;
    reg busy_r;
    reg done_r;
    reg bit_r;
    wire [W-1:0] kept_w;
    wire [W-1:0] msb_w;

    // comparator high means the held sample is at or above the trial code
    assign kept_w = comp_i ? trial_r : (trial_r & ~mask_r);
    assign msb_w = {1'b1, {(W-1){1'b0}}};

    // ---------------------------------------------------------------
    // binary search over the capacitive dac code
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trial_r <= {W{1'b0}};
            mask_r <= {W{1'b0}};
            result_r <= {W{1'b0}};
            busy_r <= 1'b0;
            done_r <= 1'b0;
            bit_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (start_i)
            begin
                trial_r <= msb_w;
                mask_r <= msb_w;
                busy_r <= 1'b1;
            end
            else if (step_i && busy_r)
            begin
                bit_r <= comp_i;
                trial_r <= kept_w | (mask_r >> 1);
                mask_r <= mask_r >> 1;
                if (mask_r[0])
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    result_r <= kept_w;
                end
            end
        end
    end

    assign trial_o = trial_r;
    assign bit_o = bit_r;
    assign busy_o = busy_r;
    assign done_o = done_r;
    assign result_o = result_r;

endmodule
`default_nettype wire

// File: verilog/adcs_sequencer.v
// control byte capture, input routing, track/hold and conversion sequencing
`timescale 1ns/10ps
`default_nettype none
`include "adcs_defs.vh"

module adcs_sequencer #(
    parameter W = `ADCS_DATA_BITS
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // serial pins from the master
    input wire sclk_i,
    input wire cs_n_i,
    input wire din_i,
    // serial data output pin
    output wire dout_o,
    output wire dout_oe_n_o,
    // analog comparator decision
    input wire comp_i,
    // input multiplexer and track/hold controls
    output wire [1:0] pos_sel_o,
    output wire [1:0] neg_sel_o,
    output wire neg_is_ref_o,
    output wire track_o,
    output wire hold_on_neg_o,
    output wire [W-1:0] dac_code_o,
    // configuration seen by the analog side
    output wire bipolar_o,
    output wire [1:0] power_mode_o,
    // conversion result
    output wire [W-1:0] result_o,
    output wire result_valid_o,
    output wire busy_o
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_CONV = 2'b10;

    reg [1:0] state_r;
    reg [`ADCS_CTRL_BITS-1:0] ctrl_r;
    reg [`ADCS_CTRL_BITS-1:0] cfg_r;
    reg [`ADCS_CNT_W-1:0] cnt_r;
    reg track_r;
    reg hold_on_neg_r;
    reg dout_r;
    reg [W-1:0] result_r;
    reg valid_r;
    reg sclk_s1_r, sclk_s2_r, sclk_d3_r;
    reg cs_s1_r, cs_s2_r;
    reg din_s1_r, din_s2_r;
    reg comp_s1_r, comp_s2_r;
    wire sclk_rise_w;
    wire sclk_fall_w;
    wire sar_start_w;
    wire sar_step_w;
    wire sar_bit_w;
    wire sar_busy_w;
    wire sar_done_w;
    wire [W-1:0] sar_result_w;
    wire [`ADCS_CTRL_BITS-1:0] byte_w;

    // ---------------------------------------------------------------
    // pin synchronisers; logic looks at the second stage, and sclk also at a third stage for its edges
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
        end
        else
        begin
            sclk_s1_r <= sclk_i;
            sclk_s2_r <= sclk_s1_r;
            sclk_d3_r <= sclk_s2_r;
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            din_s1_r <= din_i;
            din_s2_r <= din_s1_r;
            comp_s1_r <= comp_i;
            comp_s2_r <= comp_s1_r;
        end
    end

    // edge pulses, qualified by a selected device
    assign sclk_rise_w = sclk_s2_r & ~sclk_d3_r & ~cs_s2_r;
    assign sclk_fall_w = ~sclk_s2_r & sclk_d3_r & ~cs_s2_r;

    // byte as it stands once the current rising-edge bit is shifted in
    assign byte_w = {ctrl_r[`ADCS_CTRL_BITS-2:0], din_s2_r};

    // hold decision point starts the engine, later falls step it
    assign sar_start_w = sclk_fall_w && (state_r == ST_SHIFT)
        && (cnt_r == `ADCS_HOLD_BIT_CNT);
    assign sar_step_w = sclk_fall_w && (state_r == ST_CONV);

    // ---------------------------------------------------------------
    // control byte, track/hold and conversion sequencing
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            ctrl_r <= `ADCS_CTRL_RST;
            cfg_r <= `ADCS_CTRL_RST;
            cnt_r <= `ADCS_CNT_RST;
            track_r <= 1'b0;
            hold_on_neg_r <= 1'b0;
            result_r <= `ADCS_RESULT_RST;
            valid_r <= 1'b0;
        end
        else
        begin
            valid_r <= 1'b0;
            if (cs_s2_r)
            begin
                // deselect abandons a partial byte or conversion
                state_r <= ST_IDLE;
                cnt_r <= `ADCS_CNT_RST;
                hold_on_neg_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        // leading zeros are ignored until a one arrives
                        if (sclk_rise_w && din_s2_r)
                        begin
                            ctrl_r <= byte_w;
                            cnt_r <= `ADCS_CNT_FIRST;
                            state_r <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT:
                    begin
                        if (sclk_rise_w && (cnt_r != `ADCS_HOLD_BIT_CNT))
                        begin
                            ctrl_r <= byte_w;
                            cnt_r <= cnt_r + `ADCS_CNT_FIRST;
                        end
                        if (sclk_fall_w && (cnt_r == `ADCS_TRACK_BIT_CNT))
                        begin
                            track_r <= 1'b1;
                        end
                        if (sar_start_w)
                        begin
                            // three clocks after tracking began
                            track_r <= 1'b0;
                            hold_on_neg_r <= 1'b1;
                            cfg_r <= ctrl_r;
                            state_r <= ST_CONV;
                        end
                    end
                    ST_CONV:
                    begin
                        if (sar_done_w)
                        begin
                            // capacitor back on the positive node
                            hold_on_neg_r <= 1'b0;
                            track_r <= 1'b1;
                            // bipolar results read as two's complement
                            result_r <= {sar_result_w[W-1] ^ ~cfg_r[`ADCS_POL_POS],
                                sar_result_w[W-2:0]};
                            valid_r <= 1'b1;
                            cnt_r <= `ADCS_CNT_RST;
                            state_r <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // serial output: each decided bit except the last leaves on a falling edge
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dout_r <= 1'b0;
        end
        else if (sclk_fall_w)
        begin
            // shows the bit decided one fall earlier, stable for a whole clock
            dout_r <= (state_r == ST_CONV) ? sar_bit_w : 1'b0;
        end
    end

    assign dout_o = dout_r;
    assign dout_oe_n_o = cs_s2_r;

    // ---------------------------------------------------------------
    // approximation engine
    // ---------------------------------------------------------------
    adcs_sar #(
        .W(W)
    ) u_sar (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(sar_start_w),
        .step_i(sar_step_w),
        .comp_i(comp_s2_r),
        .trial_o(dac_code_o),
        .bit_o(sar_bit_w),
        .busy_o(sar_busy_w),
        .done_o(sar_done_w),
        .result_o(sar_result_w)
    );

    // ---------------------------------------------------------------
    // input routing from the latched byte
    // ---------------------------------------------------------------
    // the select msb picks the odd member, the mid bit picks the pair
    assign pos_sel_o = {cfg_r[`ADCS_SEL_MID_POS], cfg_r[`ADCS_SEL_MSB_POS]};
    // partner of the same pair, never crossing pairs
    assign neg_sel_o = {cfg_r[`ADCS_SEL_MID_POS], ~cfg_r[`ADCS_SEL_MSB_POS]};
    // single-ended returns to the reference; differential keeps the partner
    assign neg_is_ref_o = cfg_r[`ADCS_CFG_POS];
    // the capacitor only ever charges from the positive node while tracking
    assign track_o = track_r & ~hold_on_neg_r;
    assign hold_on_neg_o = hold_on_neg_r;
    assign bipolar_o = ~cfg_r[`ADCS_POL_POS];
    assign power_mode_o = {cfg_r[`ADCS_PD_HI_POS], cfg_r[`ADCS_PD_LO_POS]};
    assign result_o = result_r;
    assign result_valid_o = valid_r;
    assign busy_o = sar_busy_w | (state_r == ST_CONV);

endmodule
`default_nettype wire

// File: test/adcs_sequencer_monitor.sv
// port checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// checker
// ------------------------------------------------
module adcs_sequencer_monitor #(
    parameter W = 12
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // serial pins
    input wire sclk_i,
    input wire cs_n_i,
    input wire dout_o,
    input wire dout_oe_n_o,
    // analog side controls
    input wire [1:0] pos_sel_o,
    input wire [1:0] neg_sel_o,
    input wire neg_is_ref_o,
    input wire track_o,
    input wire hold_on_neg_o,
    input wire [W-1:0] dac_code_o,
    // result
    input wire [W-1:0] result_o,
    input wire result_valid_o,
    input wire busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // the sync delay is a few cycles, so the release may lag the pin
    chk_oe_cs_high: assert property ($rose(cs_n_i) |-> ##[1:5] dout_oe_n_o)
        else $error("output not released after select rose");
    chk_dout_fall_only: assert property ($changed(dout_o) |-> !sclk_i)
        else $error("serial output moved while serial clock high");
    chk_diff_pair: assert property (!neg_is_ref_o |-> neg_sel_o == (pos_sel_o ^ 2'h1))
        else $error("differential nodes not a fixed pair");
    chk_hold_no_track: assert property (hold_on_neg_o |-> !track_o)
        else $error("tracking while capacitor on negative node");
    chk_hold_ends_track: assert property ($rose(hold_on_neg_o) |-> $fell(track_o))
        else $error("hold did not end tracking");
    chk_hold_dac_mid: assert property ($rose(hold_on_neg_o) |-> ##[0:1] dac_code_o == 12'h800)
        else $error("first trial code not midscale");
    chk_done_retrack: assert property (result_valid_o |-> track_o && !hold_on_neg_o && !busy_o)
        else $error("no return to tracking at conversion end");
    chk_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
        else $error("result valid longer than one cycle");
    chk_result_on_done: assert property ($changed(result_o) |-> result_valid_o || $past(result_valid_o))
        else $error("result moved without completion");
endmodule
bind adcs_sequencer adcs_sequencer_monitor #(.W(W)) u_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o),
    .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o), .neg_is_ref_o(neg_is_ref_o), .track_o(track_o),
    .hold_on_neg_o(hold_on_neg_o), .dac_code_o(dac_code_o), .result_o(result_o),
    .result_valid_o(result_valid_o), .busy_o(busy_o));
`default_nettype wire

// File: test/adcs_master_model.sv
// behavioural serial master driving the converter link
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// master model
// ------------------------------------------------
module adcs_master_model (
    // serial pins toward the device
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    // serial data back
    input wire logic dout_i
);
    localparam real HALF = 62.5;
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // bit k of a frame: lead zeros, then the byte msb first, then zeros
    function automatic logic nb(input logic [7:0] c, input int lead, input int k);
        if (k < lead || k - lead > 7)
            return 1'b0;
        return c[7 - (k - lead)];
    endfunction
    // one frame; clock stands still outside it, nclk of 22 runs a full conversion
    task automatic xfer(input logic [7:0] c, input int lead, input int nclk,
        output logic [11:0] rd);
        rd = 12'h000;
        cs_n_o = 1'b0;
        din_o = nb(c, lead, 0);
        for (int k = 0; k < lead + nclk; k++)
        begin
            #(HALF - 2);
            if (k - lead >= 10)
                rd = {rd[10:0], dout_i};
            #2 sclk_o = 1'b1;
            #HALF sclk_o = 1'b0;
            din_o = nb(c, lead, k + 1);
        end
        #HALF cs_n_o = 1'b1;
        din_o = ~din_o; // released line must not keep its level
        // deselect gap so that a back-to-back frame still sees select high
        #(2 * HALF);
    endtask
endmodule
`default_nettype wire

// File: test/adcs_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// bench top
// ------------------------------------------------
module adcs_sequencer_tb;
    logic clk, rst_i, comp_i;
    logic [11:0] vin, rd, expv;
    wire sclk, cs_n, din, dout, dout_oe_n, neg_is_ref, track, hold_on_neg;
    wire bipolar, result_valid, busy;
    wire [1:0] pos_sel, neg_sel, power_mode;
    wire [11:0] dac_code, result;
    int mismatches = 0;
    int samples_checked = 0;
    int valids = 0;
    logic [2:0] c;
    adcs_sequencer u_dut (.clk_sys_i(clk), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .comp_i(comp_i),
        .pos_sel_o(pos_sel), .neg_sel_o(neg_sel), .neg_is_ref_o(neg_is_ref), .track_o(track),
        .hold_on_neg_o(hold_on_neg), .dac_code_o(dac_code), .bipolar_o(bipolar),
        .power_mode_o(power_mode), .result_o(result), .result_valid_o(result_valid),
        .busy_o(busy));
    adcs_master_model u_mst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ideal comparator against the trial code, plus completion counter
    always @(posedge clk)
    begin
        comp_i <= (vin >= dac_code);
        if (result_valid === 1'b1)
            valids <= valids + 1;
    end
    task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        test_done;
    end
    initial
    begin
        rst_i = 1'b1;
        vin = 12'h000;
        repeat (10) @(posedge clk);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk);
        chk("oe_n", 12'h001, {11'h000, dout_oe_n});
        chk("track", 12'h000, {11'h000, track});
        // aborted bytes: tracking from the fifth bit, hold from the eighth
        u_mst.xfer(8'hFF, 0, 4, rd);
        chk("track4", 12'h000, {11'h000, track});
        u_mst.xfer(8'hFF, 1, 5, rd);
        chk("track5", 12'h001, {11'h000, track});
        u_mst.xfer(8'hFF, 2, 7, rd);
        chk("track7", 12'h001, {11'h000, track});
        chk("busy7", 12'h000, {11'h000, busy});
        u_mst.xfer(8'hFF, 0, 8, rd);
        chk("track8", 12'h000, {11'h000, track});
        // full conversions back to back over channels, modes and power codes
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            vin <= 12'hFFF - c * 12'h249;
            @(posedge clk);
            u_mst.xfer({1'b1, c[0], c[1], 1'b0, c[1] ^ c[2], ~c[2], c[1:0]}, i % 3, 22, rd);
            for (int w = 0; w < 64 && busy !== 1'b0; w++)
                @(posedge clk);
            chk("busy", 12'h000, {11'h000, busy});
            if (busy !== 1'b0)
                test_done;
            expv = vin ^ ((c[1] == c[2]) ? 12'h800 : 12'h000);
            chk("pos_sel", {10'h000, c[1:0]}, {10'h000, pos_sel});
            chk("neg_is_ref", {11'h000, ~c[2]}, {11'h000, neg_is_ref});
            if (c[2])
                chk("neg_sel", {10'h000, c[1:0] ^ 2'h1}, {10'h000, neg_sel});
            chk("bipolar", {11'h000, c[1] == c[2]}, {11'h000, bipolar});
            chk("power", {10'h000, c[1:0]}, {10'h000, power_mode});
            chk("result", expv, result);
            // the line carries the raw code; the fall after the last decision shows zero
            chk("dout_bits", {vin[11:1], 1'b0}, rd);
            chk("track_end", 12'h001, {11'h000, track});
            chk("hold_end", 12'h000, {11'h000, hold_on_neg});
            chk("valids", i[11:0] + 12'h001, valids[11:0]);
            chk("oe_n_end", 12'h001, {11'h000, dout_oe_n});
        end
        test_done;
    end
endmodule
`default_nettype wire
